// >>> rtl/hpam_port.sv
// hpam_port: host side port into the dsp subsystem with ownership modes
// assumes host request pins asynchronous to i_clk (dsp core clock);
// memory and peripheral targets answer in the i_clk domain
`timescale 1ns/10ps
`default_nettype none
`include "hpam_defines.svh"
module hpam_port
    import hpam_pkg::*;
#(
    parameter int AW      = 16,
    parameter int DW      = 16,
    parameter int SINGLE_ACCESS_RAM_W = 12
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    // dsp subsystem reset level
    input  wire logic          i_dsp_rst,
    // host request, asynchronous, held until o_host_ack
    input  wire logic          i_host_req,
    input  wire logic          i_host_we,
    input  wire logic [AW-1:0] i_host_addr,
    input  wire logic [DW-1:0] i_host_wdata,
    output logic               o_host_ack,
    output logic               o_host_err,
    output logic [DW-1:0]      o_host_rdata,
    // dsp core status register 3 access
    input  wire logic          i_st3_we,
    input  wire logic [DW-1:0] i_st3_wdata,
    output logic [DW-1:0]      o_st3_rdata,
    output logic               o_bus_error,
    // dsp controllers (core and dma) memory request
    input  wire logic          i_dsp_mem_req,
    input  wire logic [AW-1:0] i_dsp_mem_addr,
    output logic               o_dsp_mem_gnt,
    input  wire logic          i_dsp_per_req,
    output logic               o_dsp_per_gnt,
    // auxiliary dma channel toward memory and peripheral targets
    output logic               o_aux_req,
    output logic               o_aux_we,
    output logic [2:0]         o_aux_target,
    output logic [AW-1:0]      o_aux_addr,
    output logic [DW-1:0]      o_aux_wdata,
    input  wire logic          i_aux_done,
    input  wire logic [DW-1:0] i_aux_rdata,
    // ownership modes currently in force
    output logic               o_mem_host_only,
    output logic               o_per_host_only
);
    // host pins pass two flops before use
    logic          req_s;
    logic          we_s;
    logic [AW-1:0] addr_s;
    logic [DW-1:0] wdata_s;
    hpam_sync2 #(.W(2 + AW + DW)) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   ({i_host_req, i_host_we, i_host_addr, i_host_wdata}),
        .o_q   ({req_s, we_s, addr_s, wdata_s})
    );

    // dsp reset is also asynchronous
    logic dsp_rst_s;
    hpam_sync2 #(.W(1)) u_rsync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   (i_dsp_rst),
        .o_q   (dsp_rst_s)
    );

    // state registers
    logic            mem_mode_q;
    logic            per_mode_q;
    logic            mem_req_q;
    logic            per_req_q;
    hpam_sw_t        sw_q;
    logic [3:0]      sw_cnt_q;
    logic            busy_q;
    logic            ack_q;
    logic            err_q;
    logic [DW-1:0]   rdata_q;
    logic [DW-1:0]   ctrl_q;
    logic [DW-1:0]   cfg_q;
    logic [AW-1:0]   last_addr_q;
    logic [DW-1:0]   last_data_q;
    logic [3:0]      dbg_flags_q;
    logic            bus_err_q;
    logic            dsp_rst_q;
    logic            req_seen_q;
    logic [2:0]      tgt_q;

    // address decode of the host request, top nibble selects space;
    // spaces E and F hold the private peripherals and are refused
    logic [3:0]      space;
    hpam_target_t    tgt;
    assign space = addr_s[AW-1 -: 4];
    always_comb begin
        if (space < 4'h8) begin
            tgt = HPAM_T_SINGLE_ACCESS_RAM;
        end else if (space < 4'hA) begin
            tgt = HPAM_T_DUAL_ACCESS_RAM;
        end else if (space == 4'hA) begin
            tgt = HPAM_T_PUBLIC;
        end else if (space == 4'hB) begin
            tgt = HPAM_T_BRIDGE;
        end else if (space == 4'hC) begin
            tgt = HPAM_T_CLKMGR;
        end else if (space == 4'hD) begin
            tgt = HPAM_T_HOSTREG;
        end else begin
            tgt = HPAM_T_PRIVATE;
        end
    end

    // single_access_ram window reserved for the host in host-only memory mode,
    // sized in sixteenths of single_access_ram counted from offset zero
    logic [`HPAM_WIN_W-1:0] win_size;
    logic [SINGLE_ACCESS_RAM_W-1:0]     dsp_off;
    logic                   dsp_in_win;
    assign win_size   = cfg_q[`HPAM_WIN_LSB +: `HPAM_WIN_W];
    assign dsp_off    = i_dsp_mem_addr[SINGLE_ACCESS_RAM_W-1:0];
    assign dsp_in_win = (i_dsp_mem_addr[AW-1 -: 4] < 4'h8) &&
                        ({1'b0, dsp_off[SINGLE_ACCESS_RAM_W-1 -: `HPAM_WIN_W]} < {1'b0, win_size});

    // a request is taken only after req_s has stood for two edges: the address
    // and data bits cross in their own flops and may trail req by one cycle
    logic req_hold_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            req_hold_q <= 1'b0;
        end else begin
            req_hold_q <= req_s;
        end
    end

    // refusal of host targets by mode; a refused access still gets an ack,
    // so the host never waits on a target that cannot answer
    logic new_req;
    logic refuse;
    logic host_reg;
    assign new_req  = req_s && req_hold_q && !req_seen_q && !busy_q && !ack_q;
    assign host_reg = (tgt == HPAM_T_HOSTREG);
    assign refuse   = (tgt == HPAM_T_PRIVATE) ||
                      (mem_mode_q && tgt == HPAM_T_DUAL_ACCESS_RAM) ||
                      (sw_q != HPAM_S_IDLE);

    // shared memory: dsp controllers are never held off by the host, only
    // by the locked single_access_ram window while memory is host-only
    logic host_mem_busy;
    assign host_mem_busy = busy_q && (tgt_q == 3'(HPAM_T_SINGLE_ACCESS_RAM) || tgt_q == 3'(HPAM_T_DUAL_ACCESS_RAM));
    assign o_dsp_mem_gnt = i_dsp_mem_req && !(mem_mode_q && dsp_in_win);
    assign o_dsp_per_gnt = i_dsp_per_req && !per_mode_q;
    // host memory transfer stalls while the dsp requests memory in shared mode; the
    // window only matters in host-only mode, so it takes no part here
    logic dsp_holds_mem;
    assign dsp_holds_mem = !mem_mode_q && i_dsp_mem_req;

    // auxiliary channel drive, held back on memory targets while the dsp owns memory
    assign o_aux_req = busy_q && !(dsp_holds_mem && host_mem_busy);
    assign o_aux_target = tgt_q;
    assign o_aux_addr   = last_addr_q;
    assign o_aux_wdata  = last_data_q;

    // host register read mux
    logic [3:0]    reg_idx;
    logic [DW-1:0] reg_rd;
    logic [DW-1:0] dsp_status;
    assign reg_idx    = addr_s[3:0];
    assign dsp_status = {{(DW-3){1'b0}}, dsp_rst_q, mem_mode_q, per_mode_q};
    assign reg_rd = (reg_idx == `HPAM_REG_CTRL)        ? ctrl_q :
                    (reg_idx == `HPAM_REG_DSP_CONFIG)  ? cfg_q :
                    (reg_idx == `HPAM_REG_LAST_ADDR)   ? DW'(last_addr_q) :
                    (reg_idx == `HPAM_REG_LAST_DATA)   ? last_data_q :
                    (reg_idx == `HPAM_REG_DEBUG_FLAGS) ? {{(DW-4){1'b0}}, dbg_flags_q} :
                    (reg_idx == `HPAM_REG_PORT_STATUS) ? {{(DW-3){1'b0}}, sw_q, busy_q} :
                    (reg_idx == `HPAM_REG_DSP_STATUS)  ? dsp_status : '0;

    // host transaction sequencing: one request per assertion of req
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            req_seen_q <= 1'b0;
            busy_q     <= 1'b0;
            ack_q      <= 1'b0;
            err_q      <= 1'b0;
            rdata_q    <= '0;
            tgt_q      <= 3'h0;
            o_aux_we   <= 1'b0;
        end else begin
            if (!req_s) begin
                req_seen_q <= 1'b0;
                ack_q      <= 1'b0;
                err_q      <= 1'b0;
            end
            if (new_req) begin
                req_seen_q <= 1'b1;
                tgt_q      <= 3'(tgt);
                o_aux_we   <= we_s;
                if (refuse) begin
                    ack_q <= 1'b1;
                    err_q <= 1'b1;
                end else if (host_reg) begin
                    ack_q   <= 1'b1;
                    rdata_q <= reg_rd;
                end else begin
                    busy_q <= 1'b1;
                end
            end else if (busy_q && i_aux_done) begin
                busy_q  <= 1'b0;
                ack_q   <= 1'b1;
                rdata_q <= i_aux_rdata;
            end
        end
    end

    // host writable control and configuration, debug capture; capture skips
    // host register accesses so the last memory or peripheral transfer stays
    // visible to the host
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q      <= `HPAM_CTRL_RESET;
            cfg_q       <= `HPAM_CFG_RESET;
            last_addr_q <= '0;
            last_data_q <= '0;
            dbg_flags_q <= 4'h0;
        end else begin
            if (new_req && host_reg && we_s && reg_idx == `HPAM_REG_CTRL) begin
                ctrl_q <= wdata_s;
            end
            if (new_req && host_reg && we_s && reg_idx == `HPAM_REG_DSP_CONFIG) begin
                cfg_q <= wdata_s;
            end
            if (new_req && !host_reg) begin
                last_addr_q <= addr_s;
                last_data_q <= wdata_s;
                dbg_flags_q <= {refuse, we_s, mem_mode_q, per_mode_q};
            end else if (busy_q && i_aux_done && !o_aux_we) begin
                last_data_q <= i_aux_rdata;
            end
        end
    end

    // mode switch: dsp core requests, controller drains then applies;
    // dsp reset entry overrides a switch in progress, and a request that
    // differs from the pending one mid-switch is dropped with a bus error
    logic mode_change;
    assign mode_change = (mem_req_q != mem_mode_q) || (per_req_q != per_mode_q);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mem_req_q  <= 1'b0;
            per_req_q  <= 1'b0;
            mem_mode_q <= 1'b0;
            per_mode_q <= 1'b0;
            sw_q       <= HPAM_S_IDLE;
            sw_cnt_q   <= 4'h0;
            bus_err_q  <= 1'b0;
            dsp_rst_q  <= 1'b0;
        end else begin
            dsp_rst_q <= dsp_rst_s;
            if (dsp_rst_s) begin
                mem_req_q  <= 1'b1;
                per_req_q  <= 1'b1;
                mem_mode_q <= 1'b1;
                per_mode_q <= 1'b1;
                sw_q       <= HPAM_S_IDLE;
            end else if (dsp_rst_q) begin
                mem_req_q  <= 1'b0;
                per_req_q  <= 1'b0;
                mem_mode_q <= 1'b0;
                per_mode_q <= 1'b0;
            end else begin
                if (i_st3_we) begin
                    if (sw_q != HPAM_S_IDLE &&
                        (i_st3_wdata[`HPAM_ST3_MEM_BIT] != mem_req_q ||
                         i_st3_wdata[`HPAM_ST3_PER_BIT] != per_req_q)) begin
                        bus_err_q <= 1'b1;
                    end else begin
                        mem_req_q <= i_st3_wdata[`HPAM_ST3_MEM_BIT];
                        per_req_q <= i_st3_wdata[`HPAM_ST3_PER_BIT];
                    end
                end
                case (sw_q)
                    HPAM_S_IDLE: begin
                        if (mode_change) begin
                            sw_q <= HPAM_S_DRAIN;
                        end
                    end
                    HPAM_S_DRAIN: begin
                        if (!busy_q && !i_dsp_mem_req && !i_dsp_per_req) begin
                            sw_q     <= HPAM_S_APPLY;
                            sw_cnt_q <= `HPAM_SWITCH_CYCLES;
                        end
                    end
                    HPAM_S_APPLY: begin
                        if (sw_cnt_q == 4'h1) begin
                            mem_mode_q <= mem_req_q;
                            per_mode_q <= per_req_q;
                            sw_q       <= HPAM_S_IDLE;
                        end
                        sw_cnt_q <= sw_cnt_q - 4'h1;
                    end
                    default: begin
                        sw_q <= HPAM_S_IDLE;
                    end
                endcase
            end
        end
    end

    // dsp core reads applied modes, never the pending request;
    // software polls these bits until they match what it wrote
    assign o_st3_rdata = (16'(1) << `HPAM_ST3_MEM_BIT) & {DW{mem_mode_q}} |
                         (16'(1) << `HPAM_ST3_PER_BIT) & {DW{per_mode_q}};
    assign o_bus_error     = bus_err_q;
    assign o_host_ack      = ack_q;
    assign o_host_err      = err_q;
    assign o_host_rdata    = rdata_q;
    assign o_mem_host_only = mem_mode_q;
    assign o_per_host_only = per_mode_q;
endmodule : hpam_port
`default_nettype wire

// >>> shared/hpam_defines.svh
// hpam_defines.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from package and rtl files
`ifndef HPAM_DEFINES_SVH
`define HPAM_DEFINES_SVH
`define HPAM_ST3_MEM_BIT      9
`define HPAM_ST3_PER_BIT      8
`define HPAM_ST3_RESET        16'h0000
`define HPAM_REG_CTRL         4'h0
`define HPAM_REG_DSP_CONFIG   4'h1
`define HPAM_REG_LAST_ADDR    4'h2
`define HPAM_REG_LAST_DATA    4'h3
`define HPAM_REG_DEBUG_FLAGS  4'h4
`define HPAM_REG_PORT_STATUS  4'h5
`define HPAM_REG_DSP_STATUS   4'h6
`define HPAM_CTRL_RESET       16'h0000
`define HPAM_CFG_RESET        16'h0000
`define HPAM_WIN_LSB          0
`define HPAM_WIN_W            4
`define HPAM_SWITCH_CYCLES    4'h4
`endif

// >>> shared/hpam_pkg.sv
// hpam_pkg: types for the host port access mode controller
// assumes hpam_defines.svh on the include path
package hpam_pkg;
    // target space decoded from the host address
    typedef enum logic [2:0] {
        HPAM_T_SINGLE_ACCESS_RAM   = 3'h0,
        HPAM_T_DUAL_ACCESS_RAM   = 3'h1,
        HPAM_T_PUBLIC  = 3'h2,
        HPAM_T_BRIDGE  = 3'h3,
        HPAM_T_CLKMGR  = 3'h4,
        HPAM_T_HOSTREG = 3'h5,
        HPAM_T_PRIVATE = 3'h6
    } hpam_target_t;
    // mode switch state, gray along idle-drain-apply
    typedef enum logic [1:0] {
        HPAM_S_IDLE  = 2'b00,
        HPAM_S_DRAIN = 2'b01,
        HPAM_S_APPLY = 2'b11
    } hpam_sw_t;
endpackage : hpam_pkg

// >>> rtl/hpam_sync2.sv
// hpam_sync2: two flop synchroniser for signals from the host domain
// assumes destination clock i_clk, async active-high reset
`timescale 1ns/10ps
`default_nettype none
module hpam_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output var  logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    // first flop feeds only the second
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule : hpam_sync2
`default_nettype wire

// >>> sim/hpam_port_chk.sv
// hpam_port_chk: pin level checks for hpam_port
// assumes bind onto hpam_port, one clock domain on i_clk
`timescale 1ns/10ps
`default_nettype none
module hpam_port_chk
    import hpam_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_dsp_rst,
    input  wire logic        i_host_req,
    input  wire logic        o_host_ack,
    input  wire logic        o_host_err,
    input  wire logic        i_st3_we,
    input  wire logic [15:0] o_st3_rdata,
    input  wire logic        i_dsp_mem_req,
    input  wire logic        o_dsp_mem_gnt,
    input  wire logic        o_dsp_per_gnt,
    input  wire logic        o_aux_req,
    input  wire logic [2:0]  o_aux_target,
    input  wire logic        o_mem_host_only,
    input  wire logic        o_per_host_only
);
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // host answers, refusals and the sync delay
    AST_ERR_ACK: assert property (o_host_err |-> o_host_ack)
        else $error("err without ack");
    AST_SYNC_LAT: assert property ($rose(i_host_req) |-> (!o_host_ack) [*3])
        else $error("ack too early");
    // where the auxiliary channel may go
    AST_NO_PRIV: assert property (o_aux_req |-> o_aux_target != HPAM_T_PRIVATE)
        else $error("private target reached");
    AST_HOM_DUAL_ACCESS_RAM: assert property (o_aux_req && o_mem_host_only |-> o_aux_target != HPAM_T_DUAL_ACCESS_RAM)
        else $error("dual_access_ram in host-only mode");
    // ownership of memory and peripherals
    AST_DSP_PRIO: assert property (i_dsp_mem_req && !o_mem_host_only |-> o_dsp_mem_gnt)
        else $error("dsp not granted");
    AST_PER_BLOCK: assert property (o_per_host_only |-> !o_dsp_per_gnt)
        else $error("dsp granted peripherals");
    AST_RST_IN: assert property ($rose(i_dsp_rst) |-> ##[2:4] (o_mem_host_only && o_per_host_only))
        else $error("no host-only on reset entry");
    AST_RST_OUT: assert property ($fell(i_dsp_rst) |-> ##[2:5] (!o_mem_host_only && !o_per_host_only))
        else $error("no shared on reset exit");
    // status bits mirror the applied modes
    AST_ST3_VIEW: assert property (o_st3_rdata == {6'h00, o_mem_host_only, o_per_host_only, 8'h00})
        else $error("status bits differ from modes");
    AST_ST3_HOLD: assert property (i_st3_we && !i_dsp_rst |=> $stable(o_st3_rdata))
        else $error("mode bits changed at once");
endmodule : hpam_port_chk
bind hpam_port hpam_port_chk hpam_port_chk_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_dsp_rst(i_dsp_rst), .i_host_req(i_host_req),
    .o_host_ack(o_host_ack), .o_host_err(o_host_err), .i_st3_we(i_st3_we), .o_st3_rdata(o_st3_rdata),
    .i_dsp_mem_req(i_dsp_mem_req), .o_dsp_mem_gnt(o_dsp_mem_gnt), .o_dsp_per_gnt(o_dsp_per_gnt),
    .o_aux_req(o_aux_req), .o_aux_target(o_aux_target), .o_mem_host_only(o_mem_host_only),
    .o_per_host_only(o_per_host_only)
);
`default_nettype wire

// >>> sim/hpam_tgt_model.sv
// hpam_tgt_model: memory and peripheral targets behind the auxiliary channel
// assumes the request is held until done, then dropped within 16 cycles
`timescale 1ns/10ps
`default_nettype none
module hpam_tgt_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic [3:0]  i_lat,
    output var  logic        o_done,
    output var  logic [15:0] o_rdata
);
    logic [15:0] mem [256];
    int          k;
    // answer only when asked, after the latency the bench picks
    initial begin
        o_done = 1'b0;
        o_rdata = 16'hA5A5;
        for (k = 0; k < 256; k++) mem[k] = 16'h0000;
        forever begin
            @(posedge i_clk);
            o_done <= 1'b0;
            o_rdata <= ~o_rdata; // no stale data between answers
            if (i_req === 1'b1 && i_rst === 1'b0) begin
                repeat (i_lat) @(posedge i_clk);
                if (i_we) mem[i_addr[7:0]] = i_wdata;
                o_done <= 1'b1;
                o_rdata <= mem[i_addr[7:0]];
                @(posedge i_clk);
                o_done <= 1'b0;
                o_rdata <= ~mem[i_addr[7:0]];
                for (k = 0; k < 16 && i_req === 1'b1; k++) @(posedge i_clk);
            end
        end
    end
endmodule : hpam_tgt_model
`default_nettype wire

// >>> sim/host_port_access_mode_ctrl_test.sv
// host_port_access_mode_ctrl_test: self-checking bench for hpam_port
// assumes hpam_tgt_model behind the auxiliary channel, 40 MHz clock
`timescale 1ns/10ps
`default_nettype none
module host_port_access_mode_ctrl_test;
    logic        clk, rst, drst, req, we, swe, dmreq, dpreq, e;
    logic        ack, err, berr, dmg, dpg, areq, awe, adone, mho, pho;
    logic [15:0] addr, wd, swd, dmaddr, hrd, srd, aaddr, awd, ard, v, r;
    logic [3:0]  lat;
    logic [2:0]  atgt;
    logic [3:0]  tops [7] = '{4'h3, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
    int          seed = 3406;
    int          fails = 0;
    int          num_checks = 0;
    int          n;

    hpam_port hpam_port_i (
        .i_clk(clk), .i_rst(rst), .i_dsp_rst(drst), .i_host_req(req), .i_host_we(we),
        .i_host_addr(addr), .i_host_wdata(wd), .o_host_ack(ack), .o_host_err(err),
        .o_host_rdata(hrd), .i_st3_we(swe), .i_st3_wdata(swd), .o_st3_rdata(srd),
        .o_bus_error(berr), .i_dsp_mem_req(dmreq), .i_dsp_mem_addr(dmaddr), .o_dsp_mem_gnt(dmg),
        .i_dsp_per_req(dpreq), .o_dsp_per_gnt(dpg), .o_aux_req(areq), .o_aux_we(awe),
        .o_aux_target(atgt), .o_aux_addr(aaddr), .o_aux_wdata(awd), .i_aux_done(adone),
        .i_aux_rdata(ard), .o_mem_host_only(mho), .o_per_host_only(pho)
    );
    hpam_tgt_model hpam_tgt_model_i (
        .i_clk(clk), .i_rst(rst), .i_req(areq), .i_we(awe), .i_addr(aaddr),
        .i_wdata(awd), .i_lat(lat), .o_done(adone), .o_rdata(ard)
    );

    // free running core clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // counts and verdict, the single end of the run
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize

    // one comparison
    task automatic chk(input string s, input logic [15:0] x, input logic [15:0] y);
        num_checks++;
        if (y !== x) begin
            fails++;
            $display("Error %s expected %h seen %h", s, x, y);
        end
    endtask : chk

    // bounded wait on ack (w=0) or the status bits (w=1)
    task automatic wt(input int w, input logic [15:0] l);
        for (n = 0; (w ? srd : {15'h0000, ack}) !== l; n++) begin
            if (n == 200) begin
                fails++;
                $display("Error wait expected %h seen %h", l, w ? srd : {15'h0000, ack});
                summarize();
            end
            @(posedge clk);
        end
    endtask : wt

    // refusal expected for a host space in shared mode
    function automatic logic [15:0] exp_err(input logic [3:0] t);
        return {15'h0000, t > 4'hD};
    endfunction : exp_err

    // target space expected for a host address nibble
    function automatic logic [15:0] exp_tgt(input logic [3:0] t);
        if (t < 4'h8) return 16'h0000;
        if (t < 4'hA) return 16'h0001;
        if (t > 4'hD) return 16'h0006;
        return {12'h000, t - 4'h8};
    endfunction : exp_tgt

    // one host word: hold until answered, then release
    task automatic host(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        req = 1'b1;
        we = w;
        addr = a;
        wd = d;
        lat = 4'($random(seed));
        wt(0, 16'h0001);
        r = hrd;
        e = err;
        @(negedge clk);
        req = 1'b0;
        wt(0, 16'h0000);
    endtask : host

    // dsp core mode request, then poll until the new bits show
    task automatic mode(input logic [15:0] m);
        logic [15:0] o;
        o = srd;
        @(negedge clk);
        swe = 1'b1;
        swd = m;
        @(negedge clk);
        swe = 1'b0;
        chk("st3 old", o, srd);
        wt(1, m);
    endtask : mode

    // main sequence
    initial begin
        {req, we, swe, dmreq, dpreq, drst, lat} = 10'h000;
        {addr, wd, swd, dmaddr} = 64'h0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk("st3 reset", 16'h0000, srd);
        // host spaces 3, 9, A, B, C, E and F once each: write, read back, refusals
        foreach (tops[i]) begin
            v = $random(seed);
            host(1'b1, {tops[i], 4'h0, 4'(i), 4'h5}, v);
            host(1'b0, {tops[i], 4'h0, 4'(i), 4'h5}, 16'h0000);
            chk("err", exp_err(tops[i]), e);
            if (tops[i] < 4'hD) chk("rdata", v, r);
            chk("target", exp_tgt(tops[i]), {13'h0000, atgt});
        end
        // host registers, read-only status ignores writes
        v = $random(seed);
        host(1'b1, 16'hD000, v);
        host(1'b1, 16'hD001, 16'h0008);
        host(1'b0, 16'hD000, 16'h0000);
        chk("ctrl", v, r);
        host(1'b0, 16'hD001, 16'h0000);
        chk("cfg", 16'h0008, r);
        host(1'b1, 16'hD006, 16'hFFFF);
        host(1'b0, 16'hD006, 16'h0000);
        chk("dstat", 16'h0000, r);
        // dsp controllers hold shared memory while the host waits
        v = $random(seed);
        dmaddr = $random(seed);
        host(1'b1, 16'h0123, v);
        fork
            host(1'b0, 16'h0123, 16'h0000);
            begin
                @(negedge clk);
                dmreq = 1'b1;
                repeat (20) @(negedge clk);
                chk("dsp gnt", 16'h0001, dmg);
                chk("host wait", 16'h0000, ack);
                chk("aux stall", 16'h0000, areq);
                dmreq = 1'b0;
            end
        join
        chk("stalled rdata", v, r);
        host(1'b0, 16'hD002, 16'h0000);
        chk("last addr", 16'h0123, r);
        host(1'b0, 16'hD003, 16'h0000);
        chk("last data", v, r);
        // host-only memory, then host-only peripherals
        mode(16'h0200);
        host(1'b0, 16'h8010, 16'h0000);
        chk("dual_access_ram", 16'h0001, e);
        v = $random(seed);
        host(1'b1, 16'h7F20, v);
        host(1'b0, 16'h7F20, 16'h0000);
        chk("single_access_ram", v, r);
        // dsp locked out of the host window, free above it
        @(negedge clk);
        dmreq = 1'b1;
        dmaddr = 16'h0100;
        @(negedge clk);
        chk("win lock", 16'h0000, dmg);
        dmaddr = 16'h0900;
        @(negedge clk);
        chk("win open", 16'h0001, dmg);
        dmreq = 1'b0;
        mode(16'h0300);
        @(negedge clk);
        dpreq = 1'b1;
        @(negedge clk);
        chk("per gnt", 16'h0000, dpg);
        dpreq = 1'b0;
        host(1'b0, 16'hD006, 16'h0000);
        chk("dstat", 16'h0003, r);
        mode(16'h0000);
        @(negedge clk);
        dpreq = 1'b1;
        @(negedge clk);
        chk("per gnt", 16'h0001, dpg);
        dpreq = 1'b0;
        // dsp reset forces host-only, release restores shared
        drst = 1'b1;
        repeat (6) @(negedge clk);
        chk("rst in", 16'h0300, srd);
        chk("modes in", 16'h0003, {14'h0000, mho, pho});
        host(1'b0, 16'h9000, 16'h0000);
        chk("dual_access_ram", 16'h0001, e);
        @(negedge clk);
        drst = 1'b0;
        repeat (6) @(negedge clk);
        chk("rst out", 16'h0000, srd);
        chk("modes out", 16'h0000, {14'h0000, mho, pho});
        chk("no bus error", 16'h0000, berr);
        // second request while a switch is in progress
        swe = 1'b1;
        swd = 16'h0200;
        @(negedge clk);
        swe = 1'b0;
        @(negedge clk);
        swe = 1'b1;
        swd = 16'h0000;
        @(negedge clk);
        swe = 1'b0;
        wt(1, 16'h0200);
        chk("bus error", 16'h0001, berr);
        summarize();
    end
endmodule : host_port_access_mode_ctrl_test
`default_nettype wire
